/* pkg/dmahs_params.svh */
// Purpose: Constants for the DMA request/grant handshake block.
// Assumes: CLK_SYS runs at 125 MHz (8 ns period).
// Notes: Timing counts are derived from the time constants below.
`ifndef DMAHS_PARAMS_SVH
`define DMAHS_PARAMS_SVH
`define DMAHS_CLK_PERIOD_NS 8
`define DMAHS_ADDR_W 32
`define DMAHS_DATA_W 48
`define DMAHS_SEL_W 4
`define DMAHS_WAIT_W 3
`define DMAHS_WIDTH_HIGH_NS 6
`define DMAHS_HIGH_CYC ((`DMAHS_WIDTH_HIGH_NS + `DMAHS_CLK_PERIOD_NS - 1) / `DMAHS_CLK_PERIOD_NS)
`define DMAHS_DEPTH_LOG2 2
`endif

/* pkg/dmahs_pkg.sv */
// Purpose: Types for the DMA request/grant handshake block.
// Assumes: Constants come from dmahs_params.svh.
// Notes: Mode encoding is an enum; strobes travel as a packed struct.
`include "dmahs_params.svh"
package dmahs_pkg;
  typedef enum logic [1:0] {
    DMAHS_MODE_HANDSHAKE,
    DMAHS_MODE_EXT_HANDSHAKE,
    DMAHS_MODE_PACED_MASTER,
    DMAHS_MODE_OFF
  } dmahs_mode_t;

  // All strobes active high here; the top module inverts all but page onto low-active pins.
  typedef struct packed {
    logic grant;
    logic rd;
    logic wr;
    logic sw;
    logic page;
  } dmahs_strobe_t;

  typedef struct packed {
    logic [`DMAHS_ADDR_W-1:0] addr;
    logic [`DMAHS_SEL_W-1:0] sel;
  } dmahs_addr_t;
endpackage

/* rtl/dmahs_sync.sv */
// Purpose: Two-flop synchroniser for the request pin.
// Assumes: Input is asynchronous to CLK_SYS.
// Notes: Resets to high, the idle level of a low-active request.
`timescale 1ns/10ps
module dmahs_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  logic q_reg;
  logic meta_next;
  logic q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b1;
      q_reg <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule

/* rtl/dmahs_top.sv */
// Purpose: Device end of a DMA request/grant handshake channel.
// Assumes: Request pin is asynchronous; transfer descriptor is held steady by the DMA core
//   while XFER_READY is high and is consumed on a pulse of XFER_TAKEN.
// Notes: Pins named _N are active low. One word moves per accepted request.
`timescale 1ns/10ps
`include "dmahs_params.svh"
module dmahs_top (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic TRANSFER_REQUEST_LINE_N,
  input wire logic [1:0] MODE,
  input wire logic [`DMAHS_WAIT_W-1:0] WAIT_STATES,
  input wire logic HOLD_IDLE_EN,
  input wire logic XFER_READY,
  input wire logic XFER_WRITE,
  input wire logic XFER_PAGE,
  input wire logic XFER_SYNC,
  input wire logic [`DMAHS_ADDR_W-1:0] XFER_ADDR,
  input wire logic [`DMAHS_SEL_W-1:0] XFER_SEL,
  input wire logic [`DMAHS_DATA_W-1:0] XFER_WDATA,
  input wire logic [`DMAHS_DATA_W-1:0] DATA_IN,
  input wire logic ACK,
  output logic XFER_TAKEN,
  output logic RDATA_VALID,
  output logic [`DMAHS_DATA_W-1:0] RDATA,
  output logic TRANSFER_GRANT_STROBE_N,
  output logic RD_N,
  output logic WR_N,
  output logic SYNC_WRITE_SELECT_N,
  output logic PAGE,
  output logic [`DMAHS_ADDR_W-1:0] ADDR,
  output logic [`DMAHS_SEL_W-1:0] MEMORY_SELECT_LINES_N,
  output logic [`DMAHS_DATA_W-1:0] DATA_OUT,
  output logic DATA_OE,
  output logic BUSY
);
  typedef enum logic [2:0] {
    S_IDLE,
    S_SETUP,
    S_ACTIVE,
    S_HOLD,
    S_RELEASE,
    S_GAP
  } dmahs_state_t;

  logic req_sync;
  logic req_low;
  logic wait_done;
  logic wait_load;
  logic [`DMAHS_WAIT_W-1:0] wait_value;

  dmahs_state_t state_reg;
  dmahs_state_t state_next;
  dmahs_pkg::dmahs_strobe_t strb_reg;
  dmahs_pkg::dmahs_strobe_t strb_next;
  dmahs_pkg::dmahs_addr_t addr_reg;
  dmahs_pkg::dmahs_addr_t addr_next;
  dmahs_pkg::dmahs_mode_t mode_reg;
  dmahs_pkg::dmahs_mode_t mode_next;
  logic write_reg;
  logic write_next;
  logic sync_reg;
  logic sync_next;
  logic [`DMAHS_DATA_W-1:0] dout_reg;
  logic [`DMAHS_DATA_W-1:0] dout_next;
  logic doe_reg;
  logic doe_next;
  logic [`DMAHS_DATA_W-1:0] rdata_reg;
  logic [`DMAHS_DATA_W-1:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic taken_reg;
  logic taken_next;
  logic [1:0] high_reg;
  logic [1:0] high_next;

  // Paced-master transfers are completed by the memory acknowledge; the others by time.
  function automatic logic uses_grant(input dmahs_pkg::dmahs_mode_t m);
    uses_grant = (m == dmahs_pkg::DMAHS_MODE_HANDSHAKE) ||
                 (m == dmahs_pkg::DMAHS_MODE_EXT_HANDSHAKE);
  endfunction

  function automatic logic uses_bus(input dmahs_pkg::dmahs_mode_t m);
    uses_bus = (m == dmahs_pkg::DMAHS_MODE_EXT_HANDSHAKE) ||
               (m == dmahs_pkg::DMAHS_MODE_PACED_MASTER);
  endfunction

  // The request pin is asynchronous; a request that misses the sampling edge is
  // simply seen one cycle later.
  dmahs_sync u_req_sync (
    .clk(CLK_SYS),
    .nrst(NRST),
    .d(TRANSFER_REQUEST_LINE_N),
    .q(req_sync)
  );

  assign req_low = !req_sync;

  dmahs_wait_cnt u_wait (
    .clk(CLK_SYS),
    .nrst(NRST),
    .load(wait_load),
    .value(wait_value),
    .done(wait_done)
  );

  always_comb begin
    state_next = state_reg;
    strb_next = strb_reg;
    addr_next = addr_reg;
    mode_next = mode_reg;
    write_next = write_reg;
    sync_next = sync_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    taken_next = 1'b0;
    high_next = high_reg;
    wait_load = 1'b0;
    wait_value = WAIT_STATES;
    case (state_reg)
      S_IDLE: begin
        if (high_reg != 2'h0) begin
          high_next = high_reg - 2'h1;
        end
        // A transfer only begins on a recognised request.
        if (req_low && XFER_READY && high_reg == 2'h0 &&
            MODE != dmahs_pkg::DMAHS_MODE_OFF) begin
          mode_next = dmahs_pkg::dmahs_mode_t'(MODE);
          write_next = XFER_WRITE;
          sync_next = XFER_SYNC;
          taken_next = 1'b1;
          // Address, selects and page are driven a cycle ahead of the grant and bus strobes.
          addr_next.addr = XFER_ADDR;
          addr_next.sel = XFER_SEL;
          strb_next.page = XFER_PAGE;
          dout_next = XFER_WDATA;
          doe_next = XFER_WRITE;
          state_next = S_SETUP;
        end
      end
      S_SETUP: begin
        // One grant pulse per accepted request; paced master leaves it idle.
        strb_next.grant = uses_grant(mode_reg);
        // External handshake and paced master drive the bus strobes.
        strb_next.rd = uses_bus(mode_reg) && !write_reg;
        strb_next.wr = uses_bus(mode_reg) && write_reg;
        strb_next.sw = uses_bus(mode_reg) && write_reg && sync_reg;
        wait_load = 1'b1;
        state_next = S_ACTIVE;
      end
      S_ACTIVE: begin
        // Wait states stretch the active window before the write strobe rises.
        if (wait_done && (uses_grant(mode_reg) || ACK)) begin
          state_next = S_HOLD;
        end
      end
      S_HOLD: begin
        // A request kept low holds the write open or stretches the read cycle by cycle.
        if (!req_low) begin
          if (!write_reg) begin
            rdata_next = DATA_IN;
            rvalid_next = 1'b1;
          end
          // Write strobe rises first; grant follows on the next edge.
          strb_next.wr = 1'b0;
          strb_next.rd = 1'b0;
          strb_next.sw = 1'b0;
          state_next = S_RELEASE;
        end
      end
      S_RELEASE: begin
        // Address and selects stay put through this edge, where grant rises.
        strb_next.grant = 1'b0;
        high_next = 2'(`DMAHS_HIGH_CYC);
        state_next = HOLD_IDLE_EN ? S_GAP : S_IDLE;
      end
      S_GAP: begin
        // Configured hold or idle cycle adds one clock before the next strobe.
        doe_next = 1'b0;
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    if (state_reg == S_IDLE && state_next == S_IDLE) begin
      doe_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state_reg <= S_IDLE;
      strb_reg <= '0;
      addr_reg <= '0;
      mode_reg <= dmahs_pkg::DMAHS_MODE_OFF;
      write_reg <= 1'b0;
      sync_reg <= 1'b0;
      dout_reg <= '0;
      doe_reg <= 1'b0;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
      taken_reg <= 1'b0;
      high_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      strb_reg <= strb_next;
      addr_reg <= addr_next;
      mode_reg <= mode_next;
      write_reg <= write_next;
      sync_reg <= sync_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      taken_reg <= taken_next;
      high_reg <= high_next;
    end
  end

  // Busy flop mirrors the next state so the port itself comes from a flip-flop.
  logic busy_reg;
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_next != S_IDLE);
    end
  end

  assign TRANSFER_GRANT_STROBE_N = !strb_reg.grant;
  assign RD_N = !strb_reg.rd;
  assign WR_N = !strb_reg.wr;
  assign SYNC_WRITE_SELECT_N = !strb_reg.sw;
  assign PAGE = strb_reg.page;
  assign ADDR = addr_reg.addr;
  assign MEMORY_SELECT_LINES_N = ~addr_reg.sel;
  assign DATA_OUT = dout_reg;
  assign DATA_OE = doe_reg;
  assign RDATA = rdata_reg;
  assign RDATA_VALID = rvalid_reg;
  assign XFER_TAKEN = taken_reg;
  assign BUSY = busy_reg;
endmodule

/* rtl/dmahs_wait_cnt.sv */
// Purpose: Loadable down-counter for wait and stretch intervals.
// Assumes: Single clock domain.
// Notes: done is high while the count is zero and load is low.
`timescale 1ns/10ps
`include "dmahs_params.svh"
module dmahs_wait_cnt (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [`DMAHS_WAIT_W-1:0] value,
  output logic done
);
  logic [`DMAHS_WAIT_W-1:0] cnt_reg;
  logic [`DMAHS_WAIT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = value;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == '0) && !load;
endmodule

/* tb/dmahs_checker.sv */
// Purpose: Timing relations on the handshake pins of dmahs_top.
// Assumes: MODE only changes while no transfer is in flight.
// Notes: Waits set by the peripheral are checked as lower bounds.
`timescale 1ns/10ps
`include "dmahs_params.svh"
module dmahs_checker (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic TRANSFER_REQUEST_LINE_N,
  input wire logic [1:0] MODE,
  input wire logic [`DMAHS_WAIT_W-1:0] WAIT_STATES,
  input wire logic HOLD_IDLE_EN,
  input wire logic XFER_TAKEN,
  input wire logic TRANSFER_GRANT_STROBE_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [`DMAHS_ADDR_W-1:0] ADDR
);
  logic [3:0] low_reg;
  logic [3:0] low_next;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  sequence grant_open;
    XFER_TAKEN ##1 !TRANSFER_GRANT_STROBE_N;
  endsequence
  // Saturates so a stuck grant cannot wrap the count back under the wait figure.
  always_comb low_next = TRANSFER_GRANT_STROBE_N ? 4'h0 : low_reg + {3'h0, low_reg != 4'hf};
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) low_reg <= 4'h0;
    else low_reg <= low_next;
  end
  a_grant_follows: assert property (XFER_TAKEN && MODE != 2'h2 |-> grant_open)
    else $error("grant did not follow the take pulse");
  a_paced_no_grant: assert property (MODE == 2'h2 |-> TRANSFER_GRANT_STROBE_N)
    else $error("grant driven in paced mode");
  a_grant_one_take: assert property ($fell(TRANSFER_GRANT_STROBE_N) |-> $past(XFER_TAKEN))
    else $error("grant pulse without a take");
  a_wr_before_grant: assert property ($rose(WR_N) && MODE != 2'h2
    |=> $rose(TRANSFER_GRANT_STROBE_N)) else $error("grant did not rise after write");
  a_addr_held: assert property (!TRANSFER_GRANT_STROBE_N |=> $stable(ADDR))
    else $error("address moved under grant");
  a_wait_grant: assert property ($rose(WR_N) && !TRANSFER_GRANT_STROBE_N
    |-> low_reg > {1'b0, WAIT_STATES}) else $error("write rose before wait states");
  a_hold_stretch: assert property (!(RD_N && WR_N) && !TRANSFER_REQUEST_LINE_N
    |=> !(RD_N && WR_N) [*2]) else $error("strobe ended under held request");
  a_gap_idle: assert property ($rose(TRANSFER_GRANT_STROBE_N) && HOLD_IDLE_EN
    |-> TRANSFER_GRANT_STROBE_N [*4]) else $error("idle gap missing");
endmodule

/* tb/dmahs_periph.sv */
// Purpose: Peripheral that requests one word per go pulse.
// Assumes: Strobes are active low and change on the rising edge.
// Notes: The data bus toggles while no strobe or grant is low, so a stale word never matches.
`timescale 1ns/10ps
`include "dmahs_params.svh"
module dmahs_periph (
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] hold,
  input wire logic [`DMAHS_DATA_W-1:0] word,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic gnt_n,
  output logic req_n,
  output logic ack,
  output logic [`DMAHS_DATA_W-1:0] data
);
  logic [3:0] n;
  logic act;
  // In plain handshake mode only the grant marks the access, so it counts as a strobe.
  assign act = !(rd_n && wr_n) || !gnt_n;
  initial begin
    req_n = 1'b1;
    ack = 1'b0;
    data = '0;
  end
  always @(negedge clk) begin
    ack <= !(rd_n && wr_n);
    data <= act ? word : ~data;
    if (go && req_n) begin
      req_n <= 1'b0;
      n <= hold;
    end else if (!req_n && act) begin
      if (n == 4'h0) req_n <= 1'b1;
      else n <= n - 4'h1;
    end
  end
endmodule

/* tb/tb_top.sv */
// Purpose: Drives transfers in every mode but off and checks the pins.
// Assumes: Peripheral model answers on the falling edge.
// Notes: Strobe-low cycles are counted to see the stretch.
`timescale 1ns/10ps
`include "dmahs_params.svh"
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_n, taken, rvalid, gnt_n, rd_n, wr_n, sw_n, page, oe, busy, ack, ready, wr, pg, hi;
  logic go = 1'b0;
  logic g_prev = 1'b1;
  logic s_cap, p_cap;
  logic [1:0] mode;
  logic [2:0] ws;
  logic [3:0] hold;
  dmahs_pkg::dmahs_addr_t desc, a_cap, pins;
  logic [`DMAHS_DATA_W-1:0] wdata, rdata, dout, din, d_cap;
  logic [`DMAHS_DATA_W-1:0] word = 48'h1234_5678_9abc;
  int err_total = 0;
  int comparisons = 0;
  int n_grant, n_low, base;
  always #4 clk = ~clk;
  dmahs_periph i_per (.clk(clk), .go(go), .hold(hold), .word(word), .rd_n(rd_n),
    .wr_n(wr_n), .gnt_n(gnt_n), .req_n(req_n), .ack(ack), .data(din));
  dmahs_top i_dut (.CLK_SYS(clk), .NRST(nrst), .TRANSFER_REQUEST_LINE_N(req_n), .MODE(mode),
    .WAIT_STATES(ws), .HOLD_IDLE_EN(hi), .XFER_READY(ready), .XFER_WRITE(wr), .XFER_PAGE(pg),
    .XFER_SYNC(1'b1), .XFER_ADDR(desc.addr), .XFER_SEL(desc.sel), .XFER_WDATA(wdata),
    .DATA_IN(din), .ACK(ack), .XFER_TAKEN(taken), .RDATA_VALID(rvalid), .RDATA(rdata),
    .TRANSFER_GRANT_STROBE_N(gnt_n), .RD_N(rd_n), .WR_N(wr_n), .SYNC_WRITE_SELECT_N(sw_n),
    .PAGE(page), .ADDR(pins.addr), .MEMORY_SELECT_LINES_N(pins.sel), .DATA_OUT(dout),
    .DATA_OE(oe), .BUSY(busy));
  always @(negedge clk) begin
    if (!gnt_n && g_prev) n_grant++;
    g_prev = gnt_n;
    if (!(rd_n && wr_n)) s_cap = sw_n;
    if (!(rd_n && wr_n) || !gnt_n) begin
      n_low++;
      a_cap = pins;
      d_cap = dout;
      p_cap = page;
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Descriptor is held until the take pulse, then the run waits for idle.
  task automatic xfer(input logic [1:0] m, input logic w, input logic [2:0] s, input logic [3:0] h);
    int t;
    @(negedge clk);
    mode = m;
    wr = w;
    pg = w ^ m[0];
    ws = s;
    hi = s[0];
    hold = h;
    desc = {32'hc000_0100 + {29'h0, m, w}, 4'h1 << m};
    wdata = {16'ha5a5, desc.addr};
    n_grant = 0;
    n_low = 0;
    ready = 1'b1;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    for (t = 0; t < 40 && taken !== 1'b1; t++) @(negedge clk);
    ready = 1'b0;
    for (t = 0; t < 80 && busy !== 1'b0; t++) @(negedge clk);
    check(busy, 1'b0);
  endtask
  initial begin
    mode = 2'h0;
    {ws, hold, hi, ready, wr, pg} = '0;
    desc = '0;
    wdata = '0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    for (int m = 0; m < 3; m++) begin
      for (int w = 0; w < 2; w++) begin
        xfer(m[1:0], w[0], 3'h0, 4'h0);
        base = n_low;
        check(n_grant, m != 2);
        check(a_cap, {desc.addr, ~desc.sel});
        if (w == 1) check(d_cap, wdata);
        else check(rdata, word);
        if (m == 1) check({s_cap, p_cap}, {~w[0], pg});
        xfer(m[1:0], w[0], 3'h0, 4'h5);
        check(n_low, base + 5);
        xfer(m[1:0], w[0], 3'h7, 4'h0);
        check(n_low > 7, 1'b1);
      end
    end
    complete_run;
  end
  initial begin
    #32000;
    err_total++;
    $display("watchdog expired at %0t", $time);
    complete_run;
  end
endmodule
bind dmahs_top dmahs_checker i_chk (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .TRANSFER_REQUEST_LINE_N(TRANSFER_REQUEST_LINE_N), .MODE(MODE), .WAIT_STATES(WAIT_STATES),
  .HOLD_IDLE_EN(HOLD_IDLE_EN), .XFER_TAKEN(XFER_TAKEN),
  .TRANSFER_GRANT_STROBE_N(TRANSFER_GRANT_STROBE_N), .RD_N(RD_N), .WR_N(WR_N), .ADDR(ADDR));
